// [hdl/clock_divider.sv]
`timescale 1ns/100ps
module clock_divider (
	// clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// divider port
	divider_if.div      port
);
	import pll_ctrl_pkg::*;

	logic [DIV_W-1:0]   count;
	logic [DIV_W-1:0]   next_count;
	logic               next_level;
	logic               next_rise;
	logic               level_q;
	logic               rise_q;

	// toggles every div_value ticks, so the level runs at tick rate / (2 * div_value)
	always_comb begin
		next_count = count;
		next_level = level_q;
		next_rise = 1'b0;
		if (port.load) begin
			next_count = {1'b0, port.init_count};
			next_level = 1'b0;
		end else if (port.tick) begin
			if (count >= port.div_value - DIV_MIN) begin
				next_count = '0;
				next_level = ~level_q;
				next_rise = ~level_q;
			end else begin
				next_count = count + DIV_MIN;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			level_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			count <= next_count;
			level_q <= next_level;
			rise_q <= next_rise;
		end
	end

	assign port.level = level_q;
	assign port.rise = rise_q;
endmodule : clock_divider

// [hdl/divider_if.sv]
`timescale 1ns/100ps
interface divider_if;
	logic                               tick;
	logic                               load;
	logic [pll_ctrl_pkg::DIV_W-1:0]     div_value;
	logic [pll_ctrl_pkg::INIT_W-1:0]    init_count;
	logic                               level;
	logic                               rise;

	modport ctrl (output tick, output load, output div_value, output init_count,
		input level, input rise);
	modport div (input tick, input load, input div_value, input init_count,
		output level, output rise);
endinterface : divider_if

// [hdl/lock_detector.sv]
`timescale 1ns/100ps
module lock_detector (
	// clock and reset
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	// control
	input  wire logic                           clear,
	input  wire logic [pll_ctrl_pkg::LOCK_W-1:0] needed,
	// edges
	input  wire logic                           ref_rise,
	input  wire logic                           fb_rise,
	// status
	output logic                                locked
);
	import pll_ctrl_pkg::*;

	logic [LOCK_W-1:0]  run_count;
	logic [LOCK_W-1:0]  next_run_count;
	logic               next_locked;

	always_comb begin
		next_run_count = run_count;
		next_locked = locked;
		if (clear) begin
			next_run_count = '0;
			next_locked = 1'b0;
		end else if (ref_rise && fb_rise) begin
			if (run_count != '1) begin
				next_run_count = run_count + 1'b1;
			end
			if (run_count + 1'b1 >= needed) begin
				next_locked = 1'b1;
			end
		end else if (ref_rise || fb_rise) begin
			next_run_count = '0;
			next_locked = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_count <= '0;
			locked <= 1'b0;
		end else begin
			run_count <= next_run_count;
			locked <= next_locked;
		end
	end
endmodule : lock_detector

// [hdl/pll_control_top.sv]
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
// Function
// - enable low holds every clock output at zero and drops lock
// - enable returning high restarts lock acquisition against the reference
// - counter reset returns all loop counters to their initial values
// - while counter reset is high, outputs are cleared and lock is dropped
// - releasing counter reset begins a fresh lock acquisition
// - detector enable gates the up and down corrections; low suppresses them
// - with detector disabled the oscillator keeps running and may drift
// - lock output high while locked, low while out of lock
// - lock may pulse during acquisition; consumers must tolerate it
// - two global outputs come from the two global dividers, either order
// - external output comes from the external divider, single or differential
// - multiply accepts 2 to 32; pre and post dividers accept 1 to 32
// - reference divided by N; oscillator at input times M/N; outputs divide it
// - each output picks one of eight phase taps and an initial count
module pll_control_top (
	// apb slave
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [pll_ctrl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                    pwdata,
	output logic [31:0]                         prdata,
	output logic                                pready,
	output logic                                pslverr,
	// dedicated reference pins
	input  wire logic                           diff_ref_a_pos,
	input  wire logic                           diff_ref_a_neg,
	// clock outputs
	output logic                                global_clock_a,
	output logic                                global_clock_b,
	output logic                                external_clock_output,
	output logic                                external_clock_output_n,
	// status
	output logic                                locked
);
	import pll_ctrl_pkg::*;

	function automatic logic [DIV_W-1:0] clamp_div(input logic [31:0] value,
		input logic [DIV_W-1:0] lo);
		logic [DIV_W-1:0] result;
		result = value[DIV_W-1:0];
		if (value < {26'h0, lo}) begin
			result = lo;
		end else if (value > {26'h0, DIV_MAX}) begin
			result = DIV_MAX;
		end
		return result;
	endfunction : clamp_div

	// registers
	logic [CTRL_W-1:0]      control;
	logic [DIV_W-1:0]       prescale;
	logic [DIV_W-1:0]       feedback;
	logic [DIV_W-1:0]       post_a;
	logic [DIV_W-1:0]       post_b;
	logic [DIV_W-1:0]       post_e;
	logic [23:0]            phase;
	logic [LOCK_W-1:0]      lock_count;
	logic [HALF_W-1:0]      vco_nominal;
	logic [CTRL_W-1:0]      next_control;
	logic [DIV_W-1:0]       next_prescale;
	logic [DIV_W-1:0]       next_feedback;
	logic [DIV_W-1:0]       next_post_a;
	logic [DIV_W-1:0]       next_post_b;
	logic [DIV_W-1:0]       next_post_e;
	logic [23:0]            next_phase;
	logic [LOCK_W-1:0]      next_lock_count;
	logic [HALF_W-1:0]      next_vco_nominal;
	logic [31:0]            next_prdata;
	logic                   next_pready;
	logic                   next_pslverr;
	logic [31:0]            read_value;
	logic                   mapped;
	logic                   do_write;

	// loop state
	logic                   run;
	logic                   det_en;
	logic                   ref_level;
	logic                   ref_prev;
	logic                   ref_edge;
	logic                   ref_rise;
	logic                   fb_rise;
	logic                   up;
	logic                   down;
	logic                   next_up;
	logic                   next_down;
	logic [HALF_W-1:0]      vco_cnt;
	logic [HALF_W-1:0]      vco_half;
	logic [HALF_W-1:0]      next_vco_cnt;
	logic [HALF_W-1:0]      next_vco_half;
	logic [HALF_W:0]        vco_sum;
	logic [1:0]             vco_step;
	logic                   vco_tick;
	logic [NUM_TAPS-2:0]    tick_hist;
	logic                   lock_raw;
	logic                   next_ga;
	logic                   next_gb;
	logic                   next_e;
	logic                   next_e_n;

	// apb decode, one wait state
	assign do_write = psel && penable && pready && pwrite;

	always_comb begin
		mapped = 1'b1;
		read_value = 32'h00000000;
		unique case (paddr)
			OFF_CONTROL:     read_value[CTRL_W-1:0] = control;
			OFF_PRESCALE:    read_value[DIV_W-1:0] = prescale;
			OFF_FEEDBACK:    read_value[DIV_W-1:0] = feedback;
			OFF_POST_A:      read_value[DIV_W-1:0] = post_a;
			OFF_POST_B:      read_value[DIV_W-1:0] = post_b;
			OFF_POST_E:      read_value[DIV_W-1:0] = post_e;
			OFF_PHASE:       read_value[23:0] = phase;
			OFF_LOCK_COUNT:  read_value[LOCK_W-1:0] = lock_count;
			OFF_VCO_NOMINAL: read_value[HALF_W-1:0] = vco_nominal;
			OFF_STATUS: begin
				read_value[STATUS_LOCKED] = locked;
				read_value[STATUS_HALF_LSB +: HALF_W] = vco_half;
			end
			default:         mapped = 1'b0;
		endcase
	end

	always_comb begin
		next_pready = psel && penable && !pready;
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (psel && penable && !pready) begin
			next_prdata = pwrite ? 32'h00000000 : read_value;
			next_pslverr = !mapped;
		end
		next_control = control;
		next_prescale = prescale;
		next_feedback = feedback;
		next_post_a = post_a;
		next_post_b = post_b;
		next_post_e = post_e;
		next_phase = phase;
		next_lock_count = lock_count;
		next_vco_nominal = vco_nominal;
		if (do_write) begin
			unique case (paddr)
				OFF_CONTROL:     next_control = pwdata[CTRL_W-1:0];
				OFF_PRESCALE:    next_prescale = clamp_div(pwdata, DIV_MIN);
				OFF_FEEDBACK:    next_feedback = clamp_div(pwdata, MUL_MIN);
				OFF_POST_A:      next_post_a = clamp_div(pwdata, DIV_MIN);
				OFF_POST_B:      next_post_b = clamp_div(pwdata, DIV_MIN);
				OFF_POST_E:      next_post_e = clamp_div(pwdata, DIV_MIN);
				OFF_PHASE:       next_phase = pwdata[23:0];
				OFF_LOCK_COUNT:  next_lock_count = pwdata[LOCK_W-1:0];
				OFF_VCO_NOMINAL: next_vco_nominal = (pwdata[HALF_W-1:0] < HALF_MIN) ?
					HALF_MIN : pwdata[HALF_W-1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			control <= CONTROL_RESET;
			prescale <= PRESCALE_RESET;
			feedback <= FEEDBACK_RESET;
			post_a <= POST_RESET;
			post_b <= POST_RESET;
			post_e <= POST_RESET;
			phase <= PHASE_RESET;
			lock_count <= LOCK_COUNT_RESET;
			vco_nominal <= VCO_NOM_RESET;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			control <= next_control;
			prescale <= next_prescale;
			feedback <= next_feedback;
			post_a <= next_post_a;
			post_b <= next_post_b;
			post_e <= next_post_e;
			phase <= next_phase;
			lock_count <= next_lock_count;
			vco_nominal <= next_vco_nominal;
		end
	end

	// loop control
	assign run = control[CTRL_ENABLE] && !control[CTRL_CNT_RESET];
	assign det_en = control[CTRL_DET_ENABLE];
	assign ref_level = control[CTRL_DIFF] ? (diff_ref_a_pos && !diff_ref_a_neg) :
		diff_ref_a_pos;
	assign ref_edge = ref_level ^ ref_prev;

	// dividers
	divider_if dv[NUM_DIV] ();

	for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
		assign dv[i].load = !run;
		clock_divider u_div (
			.pclk    (pclk),
			.presetn (presetn),
			.port    (dv[i])
		);
	end

	assign dv[DIV_PRE].tick = ref_edge;
	assign dv[DIV_PRE].div_value = prescale;
	assign dv[DIV_PRE].init_count = '0;
	assign dv[DIV_FB].tick = vco_tick;
	assign dv[DIV_FB].div_value = feedback;
	assign dv[DIV_FB].init_count = '0;
	for (genvar k = 0; k < 3; k++) begin : g_post
		logic [TAP_W-1:0] tap;
		assign tap = phase[k*LANE_W +: TAP_W];
		assign dv[DIV_A+k].tick = (tap == '0) ? vco_tick : tick_hist[tap - 1'b1];
		assign dv[DIV_A+k].init_count = phase[k*LANE_W + TAP_W +: INIT_W];
	end
	assign dv[DIV_A].div_value = post_a;
	assign dv[DIV_B].div_value = post_b;
	assign dv[DIV_E].div_value = post_e;

	assign ref_rise = dv[DIV_PRE].rise;
	assign fb_rise = dv[DIV_FB].rise;

	// oscillator and phase detector
	always_comb begin
		vco_step = 2'h1;
		if (up) begin
			vco_step = 2'h2;
		end else if (down) begin
			vco_step = 2'h0;
		end
		vco_sum = {1'b0, vco_cnt} + {15'h0, vco_step};
		vco_tick = run && (vco_sum >= {1'b0, vco_half});
		next_up = up;
		next_down = down;
		next_vco_half = vco_half;
		next_vco_cnt = vco_cnt;
		if (!run) begin
			next_up = 1'b0;
			next_down = 1'b0;
			next_vco_half = vco_nominal;
			next_vco_cnt = '0;
		end else begin
			next_vco_cnt = vco_tick ? '0 : vco_sum[HALF_W-1:0];
			if (!det_en) begin
				next_up = 1'b0;
				next_down = 1'b0;
			end else if (ref_rise && fb_rise) begin
				next_up = 1'b0;
				next_down = 1'b0;
			end else if (ref_rise) begin
				if (down) begin
					next_down = 1'b0;
					next_vco_half = (vco_half != HALF_MAX) ? vco_half + 1'b1 : vco_half;
				end else begin
					next_up = 1'b1;
				end
			end else if (fb_rise) begin
				if (up) begin
					next_up = 1'b0;
					next_vco_half = (vco_half > HALF_MIN) ? vco_half - 1'b1 : vco_half;
				end else begin
					next_down = 1'b1;
				end
			end
		end
		next_ga = run && (control[CTRL_SWAP] ? dv[DIV_B].level : dv[DIV_A].level);
		next_gb = run && (control[CTRL_SWAP] ? dv[DIV_A].level : dv[DIV_B].level);
		next_e = run && dv[DIV_E].level;
		next_e_n = run && !dv[DIV_E].level;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_prev <= 1'b0;
			up <= 1'b0;
			down <= 1'b0;
			vco_half <= VCO_NOM_RESET;
			vco_cnt <= '0;
			tick_hist <= '0;
			global_clock_a <= 1'b0;
			global_clock_b <= 1'b0;
			external_clock_output <= 1'b0;
			external_clock_output_n <= 1'b0;
		end else begin
			ref_prev <= ref_level;
			up <= next_up;
			down <= next_down;
			vco_half <= next_vco_half;
			vco_cnt <= next_vco_cnt;
			tick_hist <= {tick_hist[NUM_TAPS-3:0], vco_tick};
			global_clock_a <= next_ga;
			global_clock_b <= next_gb;
			external_clock_output <= next_e;
			external_clock_output_n <= next_e_n;
		end
	end

	lock_detector u_lock (
		.pclk     (pclk),
		.presetn  (presetn),
		.clear    (!run),
		.needed   (lock_count),
		.ref_rise (ref_rise),
		.fb_rise  (fb_rise),
		.locked   (lock_raw)
	);

	assign locked = lock_raw && run;
endmodule : pll_control_top

// [hdl/pll_ctrl_pkg.sv]
package pll_ctrl_pkg;
	// register byte offsets
	localparam int              ADDR_W          = 8;
	localparam logic [7:0]      OFF_CONTROL     = 8'h00;
	localparam logic [7:0]      OFF_PRESCALE    = 8'h04;
	localparam logic [7:0]      OFF_FEEDBACK    = 8'h08;
	localparam logic [7:0]      OFF_POST_A      = 8'h0C;
	localparam logic [7:0]      OFF_POST_B      = 8'h10;
	localparam logic [7:0]      OFF_POST_E      = 8'h14;
	localparam logic [7:0]      OFF_PHASE       = 8'h18;
	localparam logic [7:0]      OFF_LOCK_COUNT  = 8'h1C;
	localparam logic [7:0]      OFF_VCO_NOMINAL = 8'h20;
	localparam logic [7:0]      OFF_STATUS      = 8'h24;

	// control fields
	localparam int              CTRL_W          = 5;
	localparam int              CTRL_ENABLE     = 0;
	localparam int              CTRL_CNT_RESET  = 1;
	localparam int              CTRL_DET_ENABLE = 2;
	localparam int              CTRL_SWAP       = 3;
	localparam int              CTRL_DIFF       = 4;
	localparam logic [4:0]      CONTROL_RESET   = 5'h04;

	// divider values
	localparam int              DIV_W           = 6;
	localparam logic [5:0]      DIV_MIN         = 6'h01;
	localparam logic [5:0]      MUL_MIN         = 6'h02;
	localparam logic [5:0]      DIV_MAX         = 6'h20;
	localparam logic [5:0]      PRESCALE_RESET  = 6'h01;
	localparam logic [5:0]      FEEDBACK_RESET  = 6'h02;
	localparam logic [5:0]      POST_RESET      = 6'h01;

	// phase fields, one lane per output: tap in low bits, initial count above
	localparam int              TAP_W           = 3;
	localparam int              INIT_W          = 5;
	localparam int              LANE_W          = 8;
	localparam int              NUM_TAPS        = 8;
	localparam logic [23:0]     PHASE_RESET     = 24'h000000;

	// lock and oscillator
	localparam int              LOCK_W          = 16;
	localparam logic [15:0]     LOCK_COUNT_RESET = 16'h0010;
	localparam int              HALF_W          = 16;
	localparam logic [15:0]     VCO_NOM_RESET   = 16'h0004;
	localparam logic [15:0]     HALF_MIN        = 16'h0001;
	localparam logic [15:0]     HALF_MAX        = 16'hFFFF;
	localparam int              STATUS_LOCKED   = 0;
	localparam int              STATUS_HALF_LSB = 16;

	// divider slots
	localparam int              NUM_DIV         = 5;
	localparam int              DIV_PRE         = 0;
	localparam int              DIV_FB          = 1;
	localparam int              DIV_A           = 2;
	localparam int              DIV_B           = 3;
	localparam int              DIV_E           = 4;
endpackage : pll_ctrl_pkg

// [testbench/pll_control_and_status_ports_bench.sv]
`timescale 1ns/100ps
module pll_control_and_status_ports_bench;
	import pll_ctrl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic        global_clock_a, global_clock_b, external_clock_output;
	logic        external_clock_output_n, locked, ref_pos, ref_neg, ref_run, ref_diff;
	logic [7:0]  paddr;
	logic [7:0]  offs [6];
	logic [31:0] pwdata, prdata, rdat;
	logic [31:0] model [10];
	logic [31:0] vals [5];
	int          fails, n_tests, cycles, seed, i, j, c;

	pll_control_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .diff_ref_a_pos(ref_pos), .diff_ref_a_neg(ref_neg),
		.global_clock_a(global_clock_a), .global_clock_b(global_clock_b),
		.external_clock_output(external_clock_output),
		.external_clock_output_n(external_clock_output_n), .locked(locked));
	ref_source ref_u (.pclk(pclk), .presetn(presetn), .run(ref_run), .diff(ref_diff),
		.half(8'h08), .pos(ref_pos), .neg(ref_neg));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			complete_run();
		end
	end

	task complete_run();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pslverr", {31'h0, a > OFF_STATUS || a[1:0] != 2'h0}, {31'h0, rerr});
	endtask : apb

	function automatic logic [31:0] lim(logic [31:0] v, logic [31:0] lo);
		return (v < lo) ? lo : (v > 32'h20) ? 32'h20 : v;
	endfunction : lim

	task wr(input logic [7:0] a, input logic [31:0] d);
		int x;
		apb(1'b1, a, d);
		x = a >> 2;
		if (a[1:0] == 2'h0 && x < 9) begin
			case (x)
				0: model[0] = {27'h0, d[4:0]};
				1, 3, 4, 5: model[x] = lim(d, 32'h01);
				2: model[2] = lim(d, 32'h02);
				6: model[6] = {8'h0, d[23:0]};
				7: model[7] = {16'h0, d[15:0]};
				default: model[8] = (d[15:0] == 16'h0) ? 32'h1 : {16'h0, d[15:0]};
			endcase
		end
	endtask : wr

	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg_%h", a), (a > OFF_STATUS || a[1:0] != 2'h0) ? 32'h0 : model[a >> 2], rdat);
	endtask : rd

	task edges(input int sel, input int cyc, input int e);
		logic p, v;
		p = 1'b0;
		c = 0;
		repeat (cyc) begin
			@(posedge pclk);
			v = (sel == 0) ? global_clock_a : (sel == 1) ? global_clock_b : external_clock_output;
			if (v === 1'b1 && p === 1'b0) c++;
			p = v;
		end
		chk($sformatf("rises_%0d", sel), 32'h1,
			{31'h0, (e == 0) ? (c == 0) : (c >= e - 1 && c <= e + 1)});
	endtask : edges

	task wait_lock();
		int k;
		k = 0;
		while (locked !== 1'b1 && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		chk("locked", 32'h1, {31'h0, locked});
	endtask : wait_lock

	// global a on tap 3 must repeat global b three cycles later
	task tap_delay();
		logic [2:0] hb;
		hb = 3'h0;
		c = 0;
		repeat (3) begin
			@(posedge pclk);
			hb = {hb[1:0], global_clock_b};
		end
		repeat (64) begin
			@(posedge pclk);
			if (global_clock_a !== hb[2]) c++;
			hb = {hb[1:0], global_clock_b};
		end
		chk("tap_delay", 32'h0, c);
	endtask : tap_delay

	task stopped();
		repeat (2) @(posedge pclk);
		chk("locked_off", 32'h0, {31'h0, locked});
		edges(0, 64, 0);
		edges(2, 64, 0);
	endtask : stopped

	initial begin
		{psel, penable, pwrite, paddr, pwdata, ref_run, ref_diff} = '0;
		presetn = 1'b0;
		fails = 0;
		n_tests = 0;
		cycles = 0;
		seed = 84096;
		model = '{32'h04, 32'h01, 32'h02, 32'h01, 32'h01, 32'h01, 32'h0, 32'h10, 32'h04,
			32'h00040000};
		offs = '{OFF_PRESCALE, OFF_FEEDBACK, OFF_POST_A, OFF_POST_B, OFF_POST_E, OFF_VCO_NOMINAL};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i <= 40; i += 4) rd(i[7:0]);
		rd(8'h02);
		wr(OFF_STATUS, 32'hFFFFFFFF);
		wr(8'h28, 32'h0000001F);
		rd(OFF_STATUS);
		$display("test reset values done");
		for (i = 0; i < 6; i++) begin
			vals = '{32'h0, 32'h1, 32'h20, 32'h21, $random(seed)};
			for (j = 0; j < 5; j++) begin
				wr(offs[i], vals[j]);
				rd(offs[i]);
			end
		end
		$display("test divider limits done");
		foreach (vals[k]) vals[k] = 32'h1;
		vals = '{32'h1, 32'h2, 32'h1, 32'h2, 32'h1};
		for (i = 0; i < 5; i++) wr(offs[i], vals[i]);
		wr(OFF_PHASE, 32'h0);
		wr(OFF_LOCK_COUNT, 32'h4);
		wr(OFF_VCO_NOMINAL, 32'h4);
		ref_run <= 1'b1;
		wr(OFF_CONTROL, 32'h05);
		wait_lock();
		model[9] = 32'h00040001;
		rd(OFF_STATUS);
		edges(0, 160, 20);
		edges(1, 160, 10);
		edges(2, 160, 20);
		wr(OFF_CONTROL, 32'h0D);
		edges(0, 160, 10);
		edges(1, 160, 20);
		$display("test lock and rates done");
		wr(OFF_CONTROL, 32'h07);
		stopped();
		wr(OFF_CONTROL, 32'h05);
		wait_lock();
		wr(OFF_CONTROL, 32'h04);
		stopped();
		wr(OFF_CONTROL, 32'h05);
		wait_lock();
		$display("test stop and restart done");
		wr(OFF_CONTROL, 32'h04);
		wr(OFF_POST_B, 32'h1);
		wr(OFF_PHASE, 32'h00000003);
		rd(OFF_PHASE);
		wr(OFF_CONTROL, 32'h05);
		wait_lock();
		tap_delay();
		$display("test phase taps done");
		wr(OFF_CONTROL, 32'h01);
		ref_run <= 1'b0;
		edges(0, 160, 20);
		model[9] = 32'h00040000;
		rd(OFF_STATUS);
		$display("test hold-over done");
		ref_diff <= 1'b1;
		ref_run <= 1'b1;
		wr(OFF_CONTROL, 32'h15);
		wait_lock();
		edges(2, 160, 20);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		model[0] = 32'h04;
		rd(OFF_CONTROL);
		chk("locked_reset", 32'h0, {31'h0, locked});
		$display("test differential and reset done");
		complete_run();
	end
endmodule : pll_control_and_status_ports_bench

// [testbench/pll_control_props.sv]
`timescale 1ns/100ps
module pll_control_props
	import pll_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// outputs
	input  wire logic        global_clock_a,
	input  wire logic        global_clock_b,
	input  wire logic        external_clock_output,
	input  wire logic        external_clock_output_n,
	input  wire logic        locked
);
	logic [4:0] ctrl;
	logic [4:0] next_ctrl;
	logic       run;

	// shadow of the control register from apb writes
	always_comb begin
		next_ctrl = ctrl;
		if (psel && penable && pready && pwrite && paddr == OFF_CONTROL) begin
			next_ctrl = pwdata[4:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CONTROL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end
	assign run = ctrl[CTRL_ENABLE] && !ctrl[CTRL_CNT_RESET];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_answer;
		!pready ##1 pready;
	endsequence

	AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> s_answer)
		else $error("pready not after one wait state");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_SLVERR: assert property (pready |-> pslverr == (paddr > OFF_STATUS || paddr[1:0] != 2'h0))
		else $error("pslverr wrong for address");
	AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	AST_OFF_CLOCKS: assert property (!run |=> !global_clock_a && !global_clock_b
		&& !external_clock_output && !external_clock_output_n)
		else $error("clock output active while stopped");
	AST_OFF_LOCK: assert property (!run |-> !locked)
		else $error("lock high while stopped");
	AST_LOCK_AFTER_RUN: assert property ($rose(locked) |-> $past(run) && $past(run, 2))
		else $error("lock rose without running");
	AST_EXT_PAIR: assert property (run && $past(run) && $past(run, 2)
		|-> external_clock_output_n != external_clock_output)
		else $error("external pair not complementary");
	AST_STATUS_LOCK: assert property (pready && !pwrite && !pslverr && paddr == OFF_STATUS
		|-> prdata[STATUS_LOCKED] == $past(locked))
		else $error("status lock bit differs from port");
endmodule : pll_control_props

bind pll_control_top pll_control_props props_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.global_clock_a(global_clock_a), .global_clock_b(global_clock_b),
	.external_clock_output(external_clock_output),
	.external_clock_output_n(external_clock_output_n), .locked(locked));

// [testbench/ref_source.sv]
`timescale 1ns/100ps
module ref_source (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       run,
	input  wire logic       diff,
	input  wire logic [7:0] half,
	// dedicated reference pins
	output logic            pos,
	output logic            neg
);
	logic [7:0] cnt;
	logic       level;
	logic       noise;

	// reference stands low while stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt   <= 8'h00;
			level <= 1'b0;
			noise <= 1'b0;
		end else begin
			noise <= ~noise;
			if (!run) begin
				cnt   <= 8'h00;
				level <= 1'b0;
			end else if (cnt == half - 8'h01) begin
				cnt   <= 8'h00;
				level <= ~level;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end

	assign pos = level;
	// unused leg keeps changing so no stale level can pass
	assign neg = diff ? ~level : noise;
endmodule : ref_source
